/* File: core/lkd_pkg.sv */
package lkd_pkg;
   // Clock period
   localparam int unsigned CLK_NS = 5;
   // Key scan step time per scan line and its length in clock cycles
   localparam int unsigned SCAN_STEP_NS = 1000;
   localparam int unsigned SCAN_STEP_CYC = (SCAN_STEP_NS + CLK_NS - 1) / CLK_NS;
   // Register byte addresses
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_DISP = 8'h04;
   localparam logic [7:0] ADDR_KEYS = 8'h08;
   localparam logic [7:0] ADDR_STAT = 8'h0c;
   localparam logic [7:0] ADDR_IRQ = 8'h10;
   localparam logic [7:0] ADDR_MASK = 8'h14;
   // Interrupt status bit positions
   localparam int unsigned IRQ_SCAN = 0;
   localparam int unsigned IRQ_FRAME = 1;
   localparam int unsigned IRQ_W = 2;
   // Status register bit positions
   localparam int unsigned STAT_REQ = 0;
   localparam int unsigned STAT_SCAN = 1;
   localparam int unsigned STAT_CLK = 2;
   // Reset values
   localparam logic [16:0] CTRL_RST = 17'h00000;
   localparam logic [15:0] DISP_RST = 16'h0000;
   localparam logic [1:0] MASK_RST = 2'h0;
   // Frame divisors, oscillator periods per frame
   localparam logic [9:0] DIV_768 = 10'h300;
   localparam logic [9:0] DIV_576 = 10'h240;
   localparam logic [9:0] DIV_384 = 10'h180;
   localparam logic [9:0] DIV_288 = 10'h120;
   localparam logic [9:0] DIV_192 = 10'h0c0;
   // Highest legal codes
   localparam logic [2:0] STANDBY_MAX = 3'h6;
   localparam logic [2:0] PORT_MAX = 3'h4;

   // Control word, sleep bit at bit 0
   typedef struct packed {
      logic clock_source_select;
      logic [2:0] frame_divider_code;
      logic duty_select;
      logic bias_select;
      logic segments_off;
      logic [2:0] port_mux_code;
      logic [1:0] scan_pin_mux;
      logic scan_disable;
      logic [2:0] standby_line_code;
      logic sleep_select;
   } lkd_ctrl_s;

   // Key scan state
   typedef enum logic [1:0] {
      KS_IDLE = 2'b00,
      KS_SCAN = 2'b01,
      KS_DONE = 2'b10
   } lkd_scan_e;
endpackage

/* File: core/lkd_frame_div.sv */
`timescale 1ns/1ps
module lkd_frame_div (
   // Clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // Oscillator periods and selection
   input wire logic osc_tick,
   input wire logic run,
   input wire logic [2:0] code,
   // Frame pulse
   output logic frame_q
);
   logic [9:0] div;
   logic [9:0] cnt_q;

   // Divisor lookup, reserved codes fall back to the slowest frame
   always_comb begin
      unique case (code)
         3'h0: div = lkd_pkg::DIV_768;
         3'h1: div = lkd_pkg::DIV_576;
         3'h2: div = lkd_pkg::DIV_384;
         3'h3: div = lkd_pkg::DIV_288;
         3'h4: div = lkd_pkg::DIV_192;
         default: div = lkd_pkg::DIV_768;
      endcase
   end

   // Count accepted oscillator periods, pulse once per frame
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         cnt_q <= 10'h000;
         frame_q <= 1'b0;
      end else if (run && osc_tick) begin
         if (cnt_q >= div - 10'h001) begin
            cnt_q <= 10'h000;
            frame_q <= 1'b1;
         end else begin
            cnt_q <= cnt_q + 10'h001;
            frame_q <= 1'b0;
         end
      end else begin
         frame_q <= 1'b0;
      end
   end
endmodule

/* File: core/lkd_keyscan.sv */
`timescale 1ns/1ps
module lkd_keyscan #(
   parameter int unsigned STEP = lkd_pkg::SCAN_STEP_CYC
) (
   // Clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // Configuration
   input wire logic [2:0] standby_line_code,
   input wire logic scan_disable,
   input wire logic [1:0] scan_pin_mux,
   input wire logic clr_req,
   // Key matrix
   input wire logic [4:0] key_in,
   output logic [5:0] scan_lines_q,
   // Results
   output logic [29:0] key_q,
   output logic req_q,
   output logic scanning_q,
   output logic done_q
);
   lkd_pkg::lkd_scan_e state_q;
   logic [2:0] idx_q;
   logic [$clog2(STEP+1)-1:0] step_q;
   logic [2:0] n;
   logic [5:0] low_mask;
   logic [5:0] seg_mask;
   logic [5:0] scan_ok;
   logic step_end;

   // Reserved standby codes are clamped to all lines low
   assign n = (standby_line_code > lkd_pkg::STANDBY_MAX) ?
      lkd_pkg::STANDBY_MAX : standby_line_code;
   assign step_end = (step_q == ($bits(step_q))'(STEP - 1));

   // Per line masks: held low in standby, used as segment, or scannable
   for (genvar i = 0; i < 6; i++) begin : g_line
      assign low_mask[i] = (3'(i) < n);
      assign seg_mask[i] = (i < 3) && (2'(i) < scan_pin_mux);
      assign scan_ok[i] = !low_mask[i] && !seg_mask[i];
   end

   // Scan sequencer
   always_ff @(posedge clock) begin
      if (sys_rst || scan_disable) begin
         state_q <= lkd_pkg::KS_IDLE;
         idx_q <= 3'h0;
         step_q <= '0;
      end else begin
         unique case (state_q)
            lkd_pkg::KS_IDLE: begin
               idx_q <= 3'h0;
               step_q <= '0;
               if (|key_in && |scan_ok) begin
                  state_q <= lkd_pkg::KS_SCAN;
               end
            end
            lkd_pkg::KS_SCAN: begin
               step_q <= step_end ? '0 : step_q + 1'b1;
               if (step_end) begin
                  idx_q <= idx_q + 3'h1;
                  if (idx_q == 3'h5) begin
                     state_q <= lkd_pkg::KS_DONE;
                  end
               end
            end
            lkd_pkg::KS_DONE: state_q <= lkd_pkg::KS_IDLE;
            default: state_q <= lkd_pkg::KS_IDLE;
         endcase
      end
   end

   // Line drive: standby pattern, or one scannable line high during a scan
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         scan_lines_q <= 6'h00;
      end else if (state_q == lkd_pkg::KS_SCAN) begin
         scan_lines_q <= scan_ok & (6'h01 << idx_q);
      end else begin
         scan_lines_q <= ~low_mask & ~seg_mask;
      end
   end

   // Key data capture and read request
   always_ff @(posedge clock) begin
      if (sys_rst || scan_disable) begin
         key_q <= 30'h00000000;
         req_q <= 1'b0;
      end else begin
         for (int i = 0; i < 6; i++) begin
            if (state_q == lkd_pkg::KS_SCAN && step_end && idx_q == 3'(i))
               key_q[i*5 +: 5] <= scan_ok[i] ? key_in : 5'h00;
         end
         if (state_q == lkd_pkg::KS_DONE && |key_q) begin
            req_q <= 1'b1;
         end else if (clr_req) begin
            req_q <= 1'b0;
         end
      end
   end

   // Status flags
   always_ff @(posedge clock) begin
      if (sys_rst || scan_disable) begin
         scanning_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         scanning_q <= (state_q != lkd_pkg::KS_IDLE);
         done_q <= (state_q == lkd_pkg::KS_DONE);
      end
   end

   // Standby lines held low never rise
   property p_standby_low;
      @(posedge clock) disable iff (sys_rst)
      $stable(low_mask) |=> (scan_lines_q & $past(low_mask)) == 6'h00;
   endproperty
   a_standby_low: assert property (p_standby_low)
      else $error("standby low line driven high");

   // Disable clears data and request
   property p_disable;
      @(posedge clock) disable iff (sys_rst)
      scan_disable |=> key_q == 30'h00000000 && !req_q && !scanning_q;
   endproperty
   a_disable: assert property (p_disable)
      else $error("scan disable did not clear key data");
endmodule

/* File: core/lkd_top.sv */
// The strobed register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module lkd_top (
   // Clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata_q,
   // Key matrix
   input wire logic [4:0] key_in,
   output logic [5:0] scan_lines_q,
   // Oscillator pin control
   input wire logic osc_tick,
   output logic osc_run_q,
   output logic ext_clk_en_q,
   // LCD waveform control
   output logic lcd_drive_q,
   output logic seg_blank_q,
   output logic bias_half_q,
   output logic duty_third_q,
   output logic frame_q,
   // Pin muxing
   output logic [2:0] scan_seg_sel_q,
   output logic com4_seg_q,
   output logic [3:0] port_sel_q,
   output logic [3:0] gpo_q,
   // Serial data level and interrupt
   output logic key_req_n_q,
   output logic irq_q
);
   lkd_pkg::lkd_ctrl_s ctrl_q;
   logic [15:0] disp_q;
   logic [1:0] mask_q;
   logic [1:0] stat_q;
   logic [1:0] stat_d;
   logic [1:0] ev;
   logic [29:0] key_data;
   logic key_req;
   logic scanning;
   logic scan_done;
   logic clr_req;
   logic clk_run;
   logic [2:0] port_n;
   logic [3:0] port_sel_d;
   logic [3:0] gpo_d;
   logic [2:0] seg_sel_d;
   logic [31:0] rdata_d;

   // Control word
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         ctrl_q <= lkd_pkg::CTRL_RST;
      end else if (reg_wr && reg_addr == lkd_pkg::ADDR_CTRL) begin
         ctrl_q <= reg_wdata[16:0];
      end
   end

   // Low display data bits that feed the general outputs
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         disp_q <= lkd_pkg::DISP_RST;
      end else if (reg_wr && reg_addr == lkd_pkg::ADDR_DISP) begin
         disp_q <= reg_wdata[15:0];
      end
   end

   // Interrupt mask
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         mask_q <= lkd_pkg::MASK_RST;
      end else if (reg_wr && reg_addr == lkd_pkg::ADDR_MASK) begin
         mask_q <= reg_wdata[lkd_pkg::IRQ_W-1:0];
      end
   end

   // Reading key data is the controller's read, it drops the request
   assign clr_req = reg_rd && reg_addr == lkd_pkg::ADDR_KEYS;

   // Key scanner
   lkd_keyscan u_keyscan (
      .clock(clock),
      .sys_rst(sys_rst),
      .standby_line_code(ctrl_q.standby_line_code),
      .scan_disable(ctrl_q.scan_disable),
      .scan_pin_mux(ctrl_q.scan_pin_mux),
      .clr_req(clr_req),
      .key_in(key_in),
      .scan_lines_q(scan_lines_q),
      .key_q(key_data),
      .req_q(key_req),
      .scanning_q(scanning),
      .done_q(scan_done)
   );

   // Clock runs when awake, or while a scan is in progress in sleep
   assign clk_run = !ctrl_q.sleep_select || scanning;

   // Oscillator and external clock acceptance
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         osc_run_q <= 1'b0;
         ext_clk_en_q <= 1'b0;
      end else begin
         osc_run_q <= clk_run && !ctrl_q.clock_source_select;
         ext_clk_en_q <= clk_run && ctrl_q.clock_source_select;
      end
   end

   // Frame timing, counts only accepted oscillator periods
   lkd_frame_div u_frame (
      .clock(clock),
      .sys_rst(sys_rst),
      .osc_tick(osc_tick),
      .run(osc_run_q || ext_clk_en_q),
      .code(ctrl_q.frame_divider_code),
      .frame_q(frame_q)
   );

   // LCD drive mode outputs
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         lcd_drive_q <= 1'b0;
         seg_blank_q <= 1'b0;
         bias_half_q <= 1'b0;
         duty_third_q <= 1'b0;
         com4_seg_q <= 1'b0;
      end else begin
         lcd_drive_q <= !ctrl_q.sleep_select;
         seg_blank_q <= ctrl_q.segments_off;
         bias_half_q <= ctrl_q.bias_select;
         duty_third_q <= ctrl_q.duty_select;
         com4_seg_q <= ctrl_q.duty_select;
      end
   end

   // Reserved port codes are clamped to all four pins as outputs
   assign port_n = (ctrl_q.port_mux_code > lkd_pkg::PORT_MAX) ?
      lkd_pkg::PORT_MAX : ctrl_q.port_mux_code;

   // Per pin selection and general output levels
   for (genvar i = 0; i < 4; i++) begin : g_port
      assign port_sel_d[i] = (3'(i) < port_n);
      assign gpo_d[i] = port_sel_d[i] &&
         (ctrl_q.duty_select ? disp_q[3*i] : disp_q[4*i]);
   end
   for (genvar i = 0; i < 3; i++) begin : g_seg
      assign seg_sel_d[i] = (2'(i) < ctrl_q.scan_pin_mux);
   end

   // Pin mux and general output registers, unaffected by sleep
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         port_sel_q <= 4'h0;
         gpo_q <= 4'h0;
         scan_seg_sel_q <= 3'h0;
      end else begin
         port_sel_q <= port_sel_d;
         gpo_q <= gpo_d;
         scan_seg_sel_q <= seg_sel_d;
      end
   end

   // Serial output level: low while a key read is pending
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         key_req_n_q <= 1'b1;
      end else begin
         key_req_n_q <= !key_req;
      end
   end

   // Sticky events, new events win over a write-one clear
   assign ev[lkd_pkg::IRQ_SCAN] = scan_done;
   assign ev[lkd_pkg::IRQ_FRAME] = frame_q;
   always_comb begin
      stat_d = stat_q;
      if (reg_wr && reg_addr == lkd_pkg::ADDR_IRQ) begin
         stat_d = stat_d & ~reg_wdata[lkd_pkg::IRQ_W-1:0];
      end
      stat_d = stat_d | ev;
   end

   // Status and interrupt line
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         stat_q <= 2'h0;
         irq_q <= 1'b0;
      end else begin
         stat_q <= stat_d;
         irq_q <= |(stat_d & mask_q);
      end
   end

   // Read data mux, unmapped addresses read zero
   always_comb begin
      rdata_d = 32'h00000000;
      unique case (reg_addr)
         lkd_pkg::ADDR_CTRL: rdata_d[16:0] = ctrl_q;
         lkd_pkg::ADDR_DISP: rdata_d[15:0] = disp_q;
         lkd_pkg::ADDR_KEYS: rdata_d[29:0] = key_data;
         lkd_pkg::ADDR_STAT: begin
            rdata_d[lkd_pkg::STAT_REQ] = key_req;
            rdata_d[lkd_pkg::STAT_SCAN] = scanning;
            rdata_d[lkd_pkg::STAT_CLK] = osc_run_q || ext_clk_en_q;
         end
         lkd_pkg::ADDR_IRQ: rdata_d[1:0] = stat_q;
         lkd_pkg::ADDR_MASK: rdata_d[1:0] = mask_q;
         default: rdata_d = 32'h00000000;
      endcase
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         reg_rdata_q <= 32'h00000000;
      end else if (reg_rd) begin
         reg_rdata_q <= rdata_d;
      end else begin
         reg_rdata_q <= 32'h00000000;
      end
   end

   // Sleep forces the LCD pins off one cycle after the bit is set
   property p_sleep_drive;
      @(posedge clock) disable iff (sys_rst)
      ctrl_q.sleep_select |=> !lcd_drive_q;
   endproperty
   a_sleep_drive: assert property (p_sleep_drive)
      else $error("LCD drive active in sleep");

   // Oscillator halts in sleep unless a scan runs
   property p_sleep_clock;
      @(posedge clock) disable iff (sys_rst)
      ctrl_q.sleep_select && !scanning |=> !osc_run_q && !ext_clk_en_q;
   endproperty
   a_sleep_clock: assert property (p_sleep_clock)
      else $error("clock running in sleep without scan");

   // A scan keeps the internal oscillator running when it is the selected source
   property p_scan_clock;
      @(posedge clock) disable iff (sys_rst)
      scanning && !ctrl_q.clock_source_select ##1 $stable(ctrl_q)
         |-> osc_run_q;
   endproperty
   a_scan_clock: assert property (p_scan_clock)
      else $error("oscillator stopped during scan");

   // General output equals its display bit for the chosen duty
   property p_gpo_level;
      @(posedge clock) disable iff (sys_rst)
      $stable(ctrl_q) && $stable(disp_q) ##1 port_sel_q[1]
         |-> gpo_q[1] == (duty_third_q ? $past(disp_q[3])
         : $past(disp_q[4]));
   endproperty
   a_gpo_level: assert property (p_gpo_level)
      else $error("general output level mismatch");

   // Number of output pins matches the port code
   property p_port_count;
      @(posedge clock) disable iff (sys_rst)
      ctrl_q.port_mux_code == 3'h2 ##1 $stable(ctrl_q)
         |-> port_sel_q == 4'h3;
   endproperty
   a_port_count: assert property (p_port_count)
      else $error("port selection count wrong");

   // Duty select moves the fourth common pin to segment use
   property p_duty;
      @(posedge clock) disable iff (sys_rst)
      $changed(ctrl_q.duty_select) |=> com4_seg_q == duty_third_q
         && duty_third_q == $past(ctrl_q.duty_select);
   endproperty
   a_duty: assert property (p_duty)
      else $error("duty pin selection mismatch");

   // The first three scan pins become segments at the highest mux setting
   property p_scan_seg;
      @(posedge clock) disable iff (sys_rst)
      ctrl_q.scan_pin_mux == 2'h3 |=> scan_seg_sel_q == 3'h7;
   endproperty
   a_scan_seg: assert property (p_scan_seg)
      else $error("scan pin mux wrong");

   // Disabled scanning keeps the serial output high
   property p_disable_out;
      @(posedge clock) disable iff (sys_rst)
      ctrl_q.scan_disable ##2 ctrl_q.scan_disable |-> key_req_n_q;
   endproperty
   a_disable_out: assert property (p_disable_out)
      else $error("serial output low while scan disabled");

   // Blanking control follows its bit
   property p_blank;
      @(posedge clock) disable iff (sys_rst)
      ctrl_q.segments_off |=> seg_blank_q && (lcd_drive_q
         == !$past(ctrl_q.sleep_select));
   endproperty
   a_blank: assert property (p_blank)
      else $error("segment blanking not applied");

   // Awake, exactly the selected clock source runs
   property p_awake_source;
      @(posedge clock) disable iff (sys_rst)
      !ctrl_q.sleep_select ##1 $stable(ctrl_q) |-> osc_run_q ==
         !ctrl_q.clock_source_select && ext_clk_en_q ==
         ctrl_q.clock_source_select;
   endproperty
   a_awake_source: assert property (p_awake_source)
      else $error("wrong clock source running while awake");

   // No frame pulses while the clock is stopped in sleep
   property p_frame_sleep;
      @(posedge clock) disable iff (sys_rst)
      ctrl_q.sleep_select && !scanning ##1 ctrl_q.sleep_select && !scanning
         |=> !frame_q;
   endproperty
   a_frame_sleep: assert property (p_frame_sleep)
      else $error("frame pulse while clock stopped");

   // Port code zero leaves all four pins as segments
   property p_port_none;
      @(posedge clock) disable iff (sys_rst)
      ctrl_q.port_mux_code == 3'h0 |=> port_sel_q == 4'h0 && gpo_q == 4'h0;
   endproperty
   a_port_none: assert property (p_port_none)
      else $error("general output selected with port code zero");

   // Main scenarios
   c_scan_done: cover property (@(posedge clock) scan_done);
   c_sleep_scan: cover property (@(posedge clock)
      ctrl_q.sleep_select && scanning);
   c_irq: cover property (@(posedge clock) irq_q);
   c_frame: cover property (@(posedge clock) frame_q);
endmodule

/* File: bench/lkd_key_matrix.sv */
`timescale 1ns/1ps
// Key matrix: a pressed key ties its scan line to its return input
module lkd_key_matrix (
   // Scan lines and pressed keys
   input wire logic [5:0] scan_lines,
   input wire logic [29:0] pressed,
   // Returns, pulled down while no high line reaches them
   output logic [4:0] key_in
);
   // Each return sees pressed keys on lines that stand high
   always_comb begin
      key_in = 5'h00;
      for (int l = 0; l < 6; l++) begin
         if (scan_lines[l]) begin
            key_in = key_in | pressed[5*l +: 5];
         end
      end
   end
endmodule

/* File: bench/testbench.sv */
`timescale 1ns/1ps
module testbench;
   // Stimulus
   logic clock = 1'b0;
   logic sys_rst = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic osc_tick = 1'b0;
   logic [29:0] pressed = 30'h0;
   // Observed
   logic [31:0] reg_rdata_q;
   logic [4:0] key_in;
   logic [5:0] scan_lines_q;
   logic osc_run_q, ext_clk_en_q, lcd_drive_q, seg_blank_q;
   logic bias_half_q, duty_third_q, frame_q, com4_seg_q;
   logic key_req_n_q, irq_q;
   logic [2:0] scan_seg_sel_q;
   logic [3:0] port_sel_q, gpo_q;
   int failures = 0;
   int checks_done = 0;

   // 200 MHz clock and one oscillator period every two cycles
   always #2.5 clock = ~clock;
   always @(posedge clock) osc_tick <= ~osc_tick;

   lkd_top DUT (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata_q(reg_rdata_q), .key_in(key_in),
      .scan_lines_q(scan_lines_q), .osc_tick(osc_tick),
      .osc_run_q(osc_run_q), .ext_clk_en_q(ext_clk_en_q),
      .lcd_drive_q(lcd_drive_q), .seg_blank_q(seg_blank_q),
      .bias_half_q(bias_half_q), .duty_third_q(duty_third_q),
      .frame_q(frame_q), .scan_seg_sel_q(scan_seg_sel_q),
      .com4_seg_q(com4_seg_q), .port_sel_q(port_sel_q), .gpo_q(gpo_q),
      .key_req_n_q(key_req_n_q), .irq_q(irq_q));

   lkd_key_matrix keys (.scan_lines(scan_lines_q), .pressed(pressed),
      .key_in(key_in));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata_q;
   endtask

   // Let derived outputs settle after a write
   task automatic look;
      repeat (3) @(posedge clock);
      #1;
   endtask

   task automatic t_reset;
      logic [31:0] d;
      repeat (10) @(posedge clock);
      #1;
      chk(key_req_n_q, 1'b1);
      chk(lcd_drive_q, 1'b0);
      repeat (10) @(posedge clock);
      sys_rst <= 1'b0;
      look;
      chk(lcd_drive_q, 1'b1);
      rd(lkd_pkg::ADDR_CTRL, d);
      chk(d, 32'h0);
      rd(lkd_pkg::ADDR_DISP, d);
      chk(d, 32'h0);
      rd(lkd_pkg::ADDR_MASK, d);
      chk(d, 32'h0);
      rd(8'h18, d);
      chk(d, 32'h0);
   endtask

   // Every mode bit and both pin mux fields, codes within range
   task automatic t_modes;
      lkd_pkg::lkd_ctrl_s c;
      logic [31:0] d;
      logic [15:0] dd;
      logic [3:0] s, g;
      dd = 16'h1309;
      wr(lkd_pkg::ADDR_DISP, {16'h0, dd});
      for (int i = 0; i < 10; i++) begin
         c = '0;
         c.sleep_select = i[0];
         c.clock_source_select = i[1];
         c.segments_off = i[2];
         c.bias_select = i[1] ^ i[0];
         c.duty_select = (i >= 5);
         c.port_mux_code = 3'(i % 5);
         c.scan_pin_mux = i[1:0];
         wr(lkd_pkg::ADDR_CTRL, 32'(c));
         look;
         s = 4'((5'h01 << (i % 5)) - 5'h01);
         g = c.duty_select ? {dd[9], dd[6], dd[3], dd[0]}
                           : {dd[12], dd[8], dd[4], dd[0]};
         chk(lcd_drive_q, !c.sleep_select);
         chk(osc_run_q, !c.sleep_select && !i[1]);
         chk(ext_clk_en_q, !c.sleep_select && i[1]);
         chk(seg_blank_q, c.segments_off);
         chk(bias_half_q, c.bias_select);
         chk(duty_third_q, c.duty_select);
         chk(com4_seg_q, c.duty_select);
         chk(scan_seg_sel_q, 3'((4'h1 << i[1:0]) - 4'h1));
         chk(port_sel_q, s);
         chk(gpo_q, s & g);
         rd(lkd_pkg::ADDR_CTRL, d);
         chk(d, 32'(c));
      end
   endtask

   task automatic t_standby;
      lkd_pkg::lkd_ctrl_s c;
      for (int n = 0; n < 7; n++) begin
         c = '0;
         c.standby_line_code = 3'(n);
         wr(lkd_pkg::ADDR_CTRL, 32'(c));
         look;
         chk(scan_lines_q, 6'(7'h7f << n));
      end
   endtask

   // Cycles until the next frame pulse
   task automatic frame_gap(output int n);
      n = 0;
      do begin
         @(posedge clock);
         #1;
         n++;
      end while (frame_q !== 1'b1 && n < 2000);
   endtask

   task automatic t_frames;
      lkd_pkg::lkd_ctrl_s c;
      int dv [5] = '{768, 576, 384, 288, 192};
      int n;
      for (int k = 0; k < 5; k++) begin
         c = '0;
         c.frame_divider_code = 3'(k);
         wr(lkd_pkg::ADDR_CTRL, 32'(c));
         repeat (3) frame_gap(n);
         chk(n, 2 * dv[k]);
      end
   endtask

   // Press a key on line 4, release it while line 6 is scanned
   task automatic scan_once(input logic ext);
      int n;
      n = 0;
      pressed <= 30'h1 << 17;
      while (scan_lines_q !== 6'h20 && n < 2000) begin
         @(posedge clock);
         #1;
         n++;
         chk(scan_lines_q[1:0], 2'h0);
      end
      chk({osc_run_q, ext_clk_en_q}, {!ext, ext});
      pressed <= 30'h0;
      n = 0;
      while (key_req_n_q !== 1'b0 && n < 600) begin
         @(posedge clock);
         #1;
         n++;
      end
      chk(key_req_n_q, 1'b0);
   endtask

   task automatic t_scan;
      lkd_pkg::lkd_ctrl_s c;
      logic [31:0] d;
      c = '0;
      c.sleep_select = 1'b1;
      c.standby_line_code = 3'h2;
      wr(lkd_pkg::ADDR_CTRL, 32'(c));
      wr(lkd_pkg::ADDR_MASK, 32'h1);
      wr(lkd_pkg::ADDR_IRQ, 32'h3);
      pressed <= 30'h1 << 1;
      repeat (300) @(posedge clock);
      #1;
      chk(osc_run_q, 1'b0);
      chk(irq_q, 1'b0);
      rd(lkd_pkg::ADDR_STAT, d);
      chk(d, 32'h0);
      scan_once(1'b0);
      look;
      chk(irq_q, 1'b1);
      rd(lkd_pkg::ADDR_KEYS, d);
      chk(d, 32'h1 << 17);
      look;
      chk(key_req_n_q, 1'b1);
      wr(lkd_pkg::ADDR_IRQ, 32'h1);
      look;
      chk(irq_q, 1'b0);
      wr(lkd_pkg::ADDR_MASK, 32'h0);
      c.clock_source_select = 1'b1;
      wr(lkd_pkg::ADDR_CTRL, 32'(c));
      scan_once(1'b1);
      look;
      chk(irq_q, 1'b0);
      rd(lkd_pkg::ADDR_IRQ, d);
      chk(d[0], 1'b1);
      c.scan_disable = 1'b1;
      wr(lkd_pkg::ADDR_CTRL, 32'(c));
      look;
      chk(key_req_n_q, 1'b1);
      rd(lkd_pkg::ADDR_KEYS, d);
      chk(d, 32'h0);
      pressed <= 30'h1 << 17;
      repeat (300) @(posedge clock);
      rd(lkd_pkg::ADDR_STAT, d);
      chk(d[1:0], 2'h0);
      chk(key_req_n_q, 1'b1);
   endtask

   task automatic test_done;
      $display("checks_done=%0d failures=%0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // Main sequence
   initial begin
      t_reset;
      t_modes;
      t_standby;
      t_frames;
      t_scan;
      test_done;
   end

   // Watchdog: 60000 cycles, over three times the expected run of under 17000 cycles
   initial begin
      #300000;
      failures++;
      test_done;
   end
endmodule
